//--- hdl/rtcfg_i2c_target.v
/*
  Serial configuration target of the retimer: samples the bus clock and
  data pins on the internal clock, decodes start, stop, address and data
  bytes, and reads and writes the register bank by index.
  Assumes scl and sda pins are open drain with external pull-ups, the bus
  clock stays at or below 1 MHz, and chip enable is a pin of its own.
*/
// Summary of operation
// - Answer address 101000 plus select pin level.
// - Target only; never hold the clock low.
// - Work at bus clock up to 1 MHz.
// - Eight-bit bytes, most significant bit first.
// - Accesses use a register index.
// - Undefined index: writes dropped, reads give FF.
// - Pull data low through ninth clock high.
// - After start compare address; else stay silent.
// - Data falls with clock high: start.
// - Data rises with clock high: stop.
// - Index 1: class code and device code.
// - Index 2 reports 128 bytes.
// - Index 3 upper nibble: application mode.
// - Index 4 upper bits force channel power-down.
// - Index 4 bit 3 resets to one.
// - Chip enable low powers the device down.
`include "rtcfg_consts.vh"

module rtcfg_i2c_target (
  // Clock and reset
  input  wire       clk_sys_in,
  input  wire       rst_n_in,
  // Device pins
  input  wire       chip_en_in,
  input  wire       addr_select_pin_in,
  input  wire       scl_in,
  input  wire       sda_in,
  output reg        sda_out,
  output reg        sda_oe_out,
  output reg        scl_out,
  output reg        scl_oe_out,
  // Configuration to the retimer core
  output reg  [3:0] application_mode_sel_out,
  output reg        force_pd_conn_out2_out,
  output reg        force_pd_conn_in2_out,
  output reg        force_pd_conn_out1_out,
  output reg        force_pd_conn_in1_out,
  output reg        powered_down_out
);

  // --------------------------------------------------------------------
  // States
  // --------------------------------------------------------------------
  localparam [6:0] ST_IDLE  = 7'h01;
  localparam [6:0] ST_ADDR  = 7'h02;
  localparam [6:0] ST_AACK  = 7'h04;
  localparam [6:0] ST_WBYTE = 7'h08;
  localparam [6:0] ST_WACK  = 7'h10;
  localparam [6:0] ST_RBYTE = 7'h20;
  localparam [6:0] ST_RACK  = 7'h40;

  // --------------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------------
  wire scl_s;
  wire sda_s;
  wire en_s;
  wire addr_sel_s;

  rtcfg_sync2 #(.RESET_VAL(1'b1)) u_sync_scl (
    .clk_sys_in (clk_sys_in),
    .rst_n_in   (rst_n_in),
    .async_in   (scl_in),
    .sync_out   (scl_s)
  );
  rtcfg_sync2 #(.RESET_VAL(1'b1)) u_sync_sda (
    .clk_sys_in (clk_sys_in),
    .rst_n_in   (rst_n_in),
    .async_in   (sda_in),
    .sync_out   (sda_s)
  );
  rtcfg_sync2 #(.RESET_VAL(1'b1)) u_sync_en (
    .clk_sys_in (clk_sys_in),
    .rst_n_in   (rst_n_in),
    .async_in   (chip_en_in),
    .sync_out   (en_s)
  );
  rtcfg_sync2 #(.RESET_VAL(1'b0)) u_sync_sel (
    .clk_sys_in (clk_sys_in),
    .rst_n_in   (rst_n_in),
    .async_in   (addr_select_pin_in),
    .sync_out   (addr_sel_s)
  );

  // --------------------------------------------------------------------
  // Bus event detection
  // --------------------------------------------------------------------
  // At 250 MHz against a 1 MHz bus each bus phase spans about a hundred
  // samples, so plain edge detection on synchronised pins suffices.
  reg  scl_d;
  reg  sda_d;
  wire scl_rise = scl_s & ~scl_d;
  wire scl_fall = ~scl_s & scl_d;
  wire start_ev = scl_s & scl_d & sda_d & ~sda_s;
  wire stop_ev  = scl_s & scl_d & ~sda_d & sda_s;

  // --------------------------------------------------------------------
  // Engine state
  // --------------------------------------------------------------------
  reg [6:0] state;
  reg [3:0] bit_cnt;
  reg [7:0] shreg;
  reg [7:0] index;
  reg       idx_loaded;
  reg       rw_dir;
  reg       reg_wr;
  reg [7:0] tx_byte;
  reg       nak_seen;
  reg       cfg_rst_n;

  wire [7:0] rd_data;
  wire [7:0] chan_q;
  wire [7:0] pd_q;

  // A low chip enable holds the serial engine and the register bank in reset.
  always @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      cfg_rst_n <= 1'b0;
    end else begin
      cfg_rst_n <= en_s;
    end
  end

  rtcfg_regfile u_regs (
    .clk_sys_in (clk_sys_in),
    .rst_n_in   (cfg_rst_n),
    .idx_in     (index),
    .wr_in      (reg_wr),
    .wdata_in   (shreg),
    .rdata_out  (rd_data),
    .chan_out   (chan_q),
    .pd_out     (pd_q)
  );

  wire [7:0] rx_next  = {shreg[6:0], sda_s};
  wire       addr_hit = (shreg[7:2] == `RTCFG_ADDR_UPPER) &&
                        (shreg[1] == addr_sel_s);

  // --------------------------------------------------------------------
  // Serial engine
  // --------------------------------------------------------------------
  always @(posedge clk_sys_in) begin
    if (!cfg_rst_n) begin
      scl_d      <= 1'b1;
      sda_d      <= 1'b1;
      state      <= ST_IDLE;
      bit_cnt    <= 4'h0;
      shreg      <= 8'h00;
      index      <= 8'h00;
      idx_loaded <= 1'b0;
      rw_dir     <= 1'b0;
      reg_wr     <= 1'b0;
      tx_byte    <= 8'hff;
      nak_seen   <= 1'b0;
      sda_oe_out <= 1'b0;
    end else begin
      scl_d  <= scl_s;
      sda_d  <= sda_s;
      reg_wr <= 1'b0;
      if (stop_ev) begin
        state      <= ST_IDLE;
        sda_oe_out <= 1'b0;
      end else if (start_ev) begin
        state      <= ST_ADDR;
        bit_cnt    <= 4'h0;
        sda_oe_out <= 1'b0;
      end else begin
        case (state)
          ST_IDLE: begin
            sda_oe_out <= 1'b0;
          end
          ST_ADDR: begin
            if (scl_rise) begin
              shreg   <= rx_next;
              bit_cnt <= bit_cnt + 4'h1;
            end else if (scl_fall && bit_cnt == 4'h8) begin
              if (addr_hit) begin
                rw_dir     <= shreg[0];
                idx_loaded <= 1'b0;
                sda_oe_out <= 1'b1;
                state      <= ST_AACK;
              end else begin
                state <= ST_IDLE;
              end
            end
          end
          ST_AACK: begin
            if (scl_fall) begin
              bit_cnt <= 4'h0;
              if (rw_dir == `RTCFG_RW_READ) begin
                tx_byte    <= {rd_data[6:0], 1'b0};
                sda_oe_out <= ~rd_data[7];
                index      <= index + 8'h01;
                state      <= ST_RBYTE;
              end else begin
                sda_oe_out <= 1'b0;
                state      <= ST_WBYTE;
              end
            end
          end
          ST_WBYTE: begin
            if (scl_rise) begin
              shreg   <= rx_next;
              bit_cnt <= bit_cnt + 4'h1;
            end else if (scl_fall && bit_cnt == 4'h8) begin
              sda_oe_out <= 1'b1;
              state      <= ST_WACK;
              if (!idx_loaded) begin
                index      <= shreg;
                idx_loaded <= 1'b1;
              end else begin
                reg_wr <= 1'b1;
              end
            end
          end
          ST_WACK: begin
            if (reg_wr) begin
              index <= index + 8'h01;
            end
            if (scl_fall) begin
              sda_oe_out <= 1'b0;
              bit_cnt    <= 4'h0;
              state      <= ST_WBYTE;
            end
          end
          ST_RBYTE: begin
            if (scl_fall) begin
              if (bit_cnt == 4'h7) begin
                sda_oe_out <= 1'b0;
                state      <= ST_RACK;
              end else begin
                sda_oe_out <= ~tx_byte[7];
                tx_byte    <= {tx_byte[6:0], 1'b0};
                bit_cnt    <= bit_cnt + 4'h1;
              end
            end
          end
          ST_RACK: begin
            if (scl_rise) begin
              nak_seen <= sda_s;
            end else if (scl_fall) begin
              bit_cnt <= 4'h0;
              if (nak_seen) begin
                state <= ST_IDLE;
              end else begin
                tx_byte    <= {rd_data[6:0], 1'b0};
                sda_oe_out <= ~rd_data[7];
                index      <= index + 8'h01;
                state      <= ST_RBYTE;
              end
            end
          end
          default: begin
            state      <= ST_IDLE;
            sda_oe_out <= 1'b0;
          end
        endcase
      end
    end
  end

  // --------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------
  // The clock line is never driven, so the controller is never held off.
  always @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      sda_out                  <= 1'b0;
      scl_out                  <= 1'b1;
      scl_oe_out               <= 1'b0;
      application_mode_sel_out <= 4'h0;
      force_pd_conn_out2_out   <= 1'b0;
      force_pd_conn_in2_out    <= 1'b0;
      force_pd_conn_out1_out   <= 1'b0;
      force_pd_conn_in1_out    <= 1'b0;
      powered_down_out         <= 1'b1;
    end else begin
      sda_out                  <= 1'b0;
      scl_out                  <= 1'b1;
      scl_oe_out               <= 1'b0;
      application_mode_sel_out <=
        chan_q[`RTCFG_MODE_HI:`RTCFG_MODE_LO];
      force_pd_conn_out2_out   <= pd_q[`RTCFG_PD_OUT2_BIT];
      force_pd_conn_in2_out    <= pd_q[`RTCFG_PD_IN2_BIT];
      force_pd_conn_out1_out   <= pd_q[`RTCFG_PD_OUT1_BIT];
      force_pd_conn_in1_out    <= pd_q[`RTCFG_PD_IN1_BIT];
      powered_down_out         <= ~cfg_rst_n;
    end
  end

endmodule

//--- pkg/rtcfg_consts.vh
/*
  Constants for the retimer serial configuration target: register indices,
  field positions, reset values, identity values and timing figures.
  Assumes inclusion by bare name from the design files under hdl/.
*/
`ifndef RTCFG_CONSTS_VH
`define RTCFG_CONSTS_VH

// ----------------------------------------------------------------------
// Target address
// ----------------------------------------------------------------------
`define RTCFG_ADDR_UPPER        6'h28
`define RTCFG_RW_READ           1'b1

// ----------------------------------------------------------------------
// Register indices
// ----------------------------------------------------------------------
`define RTCFG_IDX_VENDOR_REV    8'h00
`define RTCFG_IDX_DEV_CLASS     8'h01
`define RTCFG_IDX_SPACE_SIZE    8'h02
`define RTCFG_IDX_CHAN_ASSIGN   8'h03
`define RTCFG_IDX_PD_OVERRIDE   8'h04

// ----------------------------------------------------------------------
// Read-only contents and reset values
// ----------------------------------------------------------------------
`define RTCFG_VENDOR_REV_VAL    8'h5a // Arbitrary identity value.
`define RTCFG_DEV_CLASS_VAL     8'h6b // Arbitrary identity value.
`define RTCFG_SPACE_SIZE_VAL    8'h80
`define RTCFG_DUMMY_VAL         8'hff
`define RTCFG_CHAN_RESET        8'h00
`define RTCFG_PD_RESET          8'h08

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define RTCFG_MODE_HI           7
`define RTCFG_MODE_LO           4
`define RTCFG_PD_OUT2_BIT       7
`define RTCFG_PD_IN2_BIT        6
`define RTCFG_PD_OUT1_BIT       5
`define RTCFG_PD_IN1_BIT        4

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define RTCFG_CLK_MHZ           250
`define RTCFG_SCL_MAX_KHZ       1000
`define RTCFG_BITCNT_W          4

`endif

//--- hdl/rtcfg_sync2.v
/*
  Two flip-flop synchroniser with a defined reset level.
  Assumes the input comes from a pin outside the clk_sys_in domain.
*/
module rtcfg_sync2 #(
  parameter RESET_VAL = 1'b1
) (
  // Clock and reset
  input  wire clk_sys_in,
  input  wire rst_n_in,
  // Data
  input  wire async_in,
  output reg  sync_out
);

  reg meta;

  always @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      meta     <= RESET_VAL;
      sync_out <= RESET_VAL;
    end else begin
      meta     <= async_in;
      sync_out <= meta;
    end
  end

endmodule

//--- hdl/rtcfg_regfile.v
/*
  Register bank of the configuration target: identity bytes, register
  space size, application mode and power-down overrides.
  Assumes one-cycle write strobes from the serial engine on the same clock.
*/
`include "rtcfg_consts.vh"

module rtcfg_regfile (
  // Clock and reset
  input  wire       clk_sys_in,
  input  wire       rst_n_in,
  // Access from the serial engine
  input  wire [7:0] idx_in,
  input  wire       wr_in,
  input  wire [7:0] wdata_in,
  output reg  [7:0] rdata_out,
  // Stored configuration
  output reg  [7:0] chan_out,
  output reg  [7:0] pd_out
);

  always @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      chan_out <= `RTCFG_CHAN_RESET;
      pd_out   <= `RTCFG_PD_RESET;
    end else if (wr_in) begin
      case (idx_in)
        `RTCFG_IDX_CHAN_ASSIGN: chan_out <= wdata_in;
        `RTCFG_IDX_PD_OVERRIDE: pd_out   <= wdata_in;
        default: ;
      endcase
    end
  end

  always @* begin
    case (idx_in)
      `RTCFG_IDX_VENDOR_REV:  rdata_out = `RTCFG_VENDOR_REV_VAL;
      `RTCFG_IDX_DEV_CLASS:   rdata_out = `RTCFG_DEV_CLASS_VAL;
      `RTCFG_IDX_SPACE_SIZE:  rdata_out = `RTCFG_SPACE_SIZE_VAL;
      `RTCFG_IDX_CHAN_ASSIGN: rdata_out = chan_out;
      `RTCFG_IDX_PD_OVERRIDE: rdata_out = pd_out;
      default:                rdata_out = `RTCFG_DUMMY_VAL;
    endcase
  end

endmodule

//--- test/rtcfg_ctl_model.sv
/*
  Behavioural bus controller: drives the serial clock and data lines
  through open-drain pull-downs and moves one byte per call.
  Assumes pull-ups on both lines and the 250 MHz bench clock.
*/
module rtcfg_ctl_model (
  // Clock
  input  wire clk_in,
  // Bus lines
  input  wire sda_in,
  output reg  scl_low_out,
  output reg  sda_low_out
);
  timeunit 1ns;
  timeprecision 1ps;

  // ------------------------------------------------------------------
  // Bit timing
  // ------------------------------------------------------------------
  // A quarter bit of 63 cycles keeps the bus clock just under 1 MHz.
  localparam int QTR = 63;

  initial begin
    scl_low_out = 1'b0;
    sda_low_out = 1'b0;
  end

  task automatic qtr();
    repeat (QTR) @(negedge clk_in);
  endtask

  // ------------------------------------------------------------------
  // Bus conditions
  // ------------------------------------------------------------------
  task automatic start();
    sda_low_out = 1'b0;
    qtr();
    scl_low_out = 1'b0;
    qtr();
    sda_low_out = 1'b1;
    qtr();
    scl_low_out = 1'b1;
    qtr();
  endtask

  task automatic stop();
    sda_low_out = 1'b1;
    qtr();
    scl_low_out = 1'b0;
    qtr();
    sda_low_out = 1'b0;
    qtr();
  endtask

  task automatic bit_xfer(input logic b, output logic r);
    sda_low_out = !b;
    qtr();
    scl_low_out = 1'b0;
    qtr();
    r = sda_in;
    qtr();
    scl_low_out = 1'b1;
    qtr();
  endtask

  // Writes send d and sample ack; reads send ff and set last for nak.
  task automatic byte_xfer(input logic [7:0] d, input logic last,
                           output logic [7:0] q, output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--) bit_xfer(d[i], q[i]);
    bit_xfer(last, a);
    ack = !a;
  endtask
endmodule

//--- test/rtcfg_i2c_target_properties.sv
/*
  Checker of the serial configuration target, seeing its ports only.
  Assumes the bench keeps chip enable changes to idle bus periods.
*/
module rtcfg_i2c_target_chk (
  // Clock and reset
  input logic       clk_sys_in,
  input logic       rst_n_in,
  // Pins
  input logic       chip_en_in,
  input logic       scl_in,
  input logic       sda_out,
  input logic       sda_oe_out,
  input logic       scl_oe_out,
  // Configuration
  input logic [3:0] application_mode_sel_out,
  input logic       force_pd_conn_out2_out,
  input logic       force_pd_conn_in2_out,
  input logic       force_pd_conn_out1_out,
  input logic       force_pd_conn_in1_out,
  input logic       powered_down_out
);
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!rst_n_in);

  wire [7:0] cfg = {application_mode_sel_out, force_pd_conn_out2_out,
    force_pd_conn_in2_out, force_pd_conn_out1_out, force_pd_conn_in1_out};

  sequence scl_high_run;
    scl_in [*6];
  endsequence
  sequence en_low_run;
    !chip_en_in [*8];
  endsequence
  sequence en_high_run;
    chip_en_in [*8];
  endsequence

  a_clock_never_held: assert property (!scl_oe_out)
    else $error("clock line pulled low");
  a_pull_low_only: assert property (sda_oe_out |-> !sda_out)
    else $error("data line driven high");
  a_ack_through_high: assert property (
    scl_high_run |-> $stable(sda_oe_out))
    else $error("data drive changed in clock high");
  a_drive_clock_low: assert property ($rose(sda_oe_out) |-> !scl_in)
    else $error("data drive began in clock high");
  a_drive_min_width: assert property (
    $rose(sda_oe_out) |=> sda_oe_out [*8])
    else $error("data drive too short");
  a_off_when_down: assert property (powered_down_out |-> !sda_oe_out)
    else $error("drive while powered down");
  a_down_follows_en: assert property (en_low_run |-> powered_down_out)
    else $error("not powered down");
  a_up_follows_en: assert property (en_high_run |-> !powered_down_out)
    else $error("still powered down");
  a_cfg_clear_down: assert property (
    powered_down_out [*3] |-> cfg == 8'h00)
    else $error("config not cleared");
  a_cfg_change_ack: assert property (
    !$stable(cfg) |-> $past(sda_oe_out) || powered_down_out
    || $past(powered_down_out))
    else $error("config changed outside a write");
endmodule

bind rtcfg_i2c_target rtcfg_i2c_target_chk u_chk (
  .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .chip_en_in(chip_en_in),
  .scl_in(scl_in), .sda_out(sda_out), .sda_oe_out(sda_oe_out),
  .scl_oe_out(scl_oe_out),
  .application_mode_sel_out(application_mode_sel_out),
  .force_pd_conn_out2_out(force_pd_conn_out2_out),
  .force_pd_conn_in2_out(force_pd_conn_in2_out),
  .force_pd_conn_out1_out(force_pd_conn_out1_out),
  .force_pd_conn_in1_out(force_pd_conn_in1_out),
  .powered_down_out(powered_down_out));

//--- test/retimer_i2c_config_slave_test.sv
/*
  Self-checking bench of the serial configuration target: indexed
  reads and writes, address filtering and chip enable.
  Assumes the controller model and the checker are compiled first.
*/
`include "rtcfg_consts.vh"

module retimer_i2c_config_slave_test;
  timeunit 1ns;
  timeprecision 1ps;

  // ------------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------------
  localparam int LIMIT = 98000;
  logic       clk_sys_in = 1'b0;
  logic       rst_n_in   = 1'b0;
  logic       chip_en_in = 1'b1;
  logic       sel        = 1'b0;
  wire        scl_low, sda_low, sda_out, sda_oe, scl_out, scl_oe, down;
  wire  [3:0] mode;
  wire  [3:0] frc;
  wire        scl = !(scl_low || (scl_oe && !scl_out));
  wire        sda = !(sda_low || (sda_oe && !sda_out));
  logic [7:0] m3, m4, ix, q;
  logic       ack;
  int         num_errors = 0;
  int         n_checks   = 0;
  int         cyc        = 0;
  int         s;

  rtcfg_i2c_target dut (
    .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
    .chip_en_in(chip_en_in), .addr_select_pin_in(sel),
    .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe_out(sda_oe), .scl_out(scl_out), .scl_oe_out(scl_oe),
    .application_mode_sel_out(mode),
    .force_pd_conn_out2_out(frc[3]), .force_pd_conn_in2_out(frc[2]),
    .force_pd_conn_out1_out(frc[1]), .force_pd_conn_in1_out(frc[0]),
    .powered_down_out(down));
  rtcfg_ctl_model ctl (.clk_in(clk_sys_in), .sda_in(sda),
    .scl_low_out(scl_low), .sda_low_out(sda_low));

  always #2 clk_sys_in = !clk_sys_in;

  always @(posedge clk_sys_in) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      num_errors = num_errors + 1;
      report_and_stop();
    end
  end

  // ------------------------------------------------------------------
  // Checks and expectations
  // ------------------------------------------------------------------
  task automatic chk_byte(input string n, input logic [7:0] e, g);
    n_checks++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic chk_bit(input string n, input logic e, g);
    n_checks++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value %s expected %b seen %b", n, e, g);
    end
  endtask

  function automatic logic [7:0] exp_rd(input logic [7:0] i);
    case (i)
      8'h00: exp_rd = `RTCFG_VENDOR_REV_VAL;
      8'h01: exp_rd = `RTCFG_DEV_CLASS_VAL;
      8'h02: exp_rd = 8'h80;
      8'h03: exp_rd = m3;
      8'h04: exp_rd = m4;
      default: exp_rd = 8'hff;
    endcase
  endfunction

  function automatic logic [7:0] adr(input logic rw);
    adr = {6'b101000, sel, rw};
  endfunction

  task automatic cfg_chk();
    chk_byte("mode", {4'h0, m3[7:4]}, {4'h0, mode});
    chk_byte("forces", {4'h0, m4[7:4]}, {4'h0, frc});
    chk_bit("scl_drive", 1'b0, scl_oe);
    chk_bit("scl_level", 1'b1, scl_out);
  endtask

  // ------------------------------------------------------------------
  // Transfers
  // ------------------------------------------------------------------
  task automatic wr(input logic [7:0] i, input int n,
                    input logic [7:0] d0, d1, d2);
    logic [7:0] dv [3];
    dv = '{d0, d1, d2};
    ctl.start();
    ctl.byte_xfer(adr(1'b0), 1'b1, q, ack);
    chk_bit("addr_ack", 1'b1, ack);
    ctl.byte_xfer(i, 1'b1, q, ack);
    chk_bit("index_ack", 1'b1, ack);
    ix = i;
    for (int k = 0; k < n; k++) begin
      ctl.byte_xfer(dv[k], 1'b1, q, ack);
      chk_bit("data_ack", 1'b1, ack);
      if (ix == 8'h03) m3 = dv[k];
      if (ix == 8'h04) m4 = dv[k];
      ix++;
    end
    ctl.stop();
  endtask

  task automatic rd(input int n);
    ctl.start();
    ctl.byte_xfer(adr(1'b1), 1'b1, q, ack);
    chk_bit("addr_ack", 1'b1, ack);
    for (int k = 0; k < n; k++) begin
      ctl.byte_xfer(8'hff, k == n - 1, q, ack);
      chk_byte("read_data", exp_rd(ix), q);
      ix++;
    end
    ctl.stop();
  endtask

  task automatic report_and_stop();
    if (num_errors == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // ------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------
  initial begin
    s = $urandom(73);
    m3 = 8'h00;
    m4 = 8'h08;
    repeat (6) @(negedge clk_sys_in);
    rst_n_in = 1'b1;
    repeat (10) @(negedge clk_sys_in);
    chk_bit("down", 1'b0, down);
    cfg_chk();
    wr(8'h00, 0, 0, 0, 0);
    rd(5);
    wr(8'h03, 3, 8'($urandom), 8'($urandom), 8'($urandom));
    cfg_chk();
    wr(8'h03, 0, 0, 0, 0);
    rd(3);
    wr(8'h01, 2, 8'($urandom), 8'($urandom), 0);
    wr(8'h01, 0, 0, 0, 0);
    rd(2);
    // A foreign address differing only in the select bit comes first.
    for (int k = 0; k < 2; k++) begin
      sel = k[0];
      s = (k == 0) ? 1 : $urandom_range(127, 1);
      repeat (8) @(negedge clk_sys_in);
      ctl.start();
      ctl.byte_xfer(adr(1'b0) ^ {s[6:0], 1'b0}, 1'b1, q, ack);
      chk_bit("foreign_ack", 1'b0, ack);
      ctl.stop();
      ctl.start();
      ctl.byte_xfer(adr(1'b0), 1'b1, q, ack);
      chk_bit("own_ack", 1'b1, ack);
      ctl.stop();
    end
    chip_en_in = 1'b0;
    repeat (10) @(negedge clk_sys_in);
    chk_bit("down", 1'b1, down);
    m3 = 8'h00;
    m4 = 8'h08;
    cfg_chk();
    chip_en_in = 1'b1;
    repeat (10) @(negedge clk_sys_in);
    chk_bit("down", 1'b0, down);
    wr(8'h03, 0, 0, 0, 0);
    rd(2);
    report_and_stop();
  end
endmodule
